//--- verilog/pgl_consts.vh
`ifndef PGL_CONSTS_VH
`define PGL_CONSTS_VH

// Sample and table geometry
`define PGL_DATA_W        8
`define PGL_ADDR_W        8
`define PGL_TABLE_DEPTH   256

// Output buffer geometry
`define PGL_FIFO_DEPTH    32
`define PGL_FIFO_AW       5
`define PGL_FIFO_CW       6
// Upstream ready drops once more than this many words are held (depth minus 8 words of slack)
`define PGL_READY_LIMIT   6'h18

// Memory style selection codes
`define PGL_MEM_BLOCK     2'h0
`define PGL_MEM_DIST      2'h1
`define PGL_MEM_AUTO      2'h2

// Width thresholds for the memory style decision
`define PGL_BLOCK_ABOVE_W 4
`define PGL_DIST_BELOW_W  9
`define PGL_AUTO_DIST_W   7

// Latency without optional stages, in clock cycles
`define PGL_LAT_BASE      4

// Reset values
`define PGL_FLAG_RST      1'h0
`define PGL_DATA_RST      8'h00

`endif

//--- verilog/pgl_lut_mem.v
`timescale 1ns/1ns
module pgl_lut_mem
#(
  parameter DATA_W  = 8,
  parameter ADDR_W  = 8,
  parameter DEPTH   = 256,
  parameter OUT_REG = 0
)
(
  input  wire              core_clk_in,
  input  wire              wr_en_in,
  input  wire [ADDR_W-1:0] wr_addr_in,
  input  wire [DATA_W-1:0] wr_data_in,
  input  wire              rd_en_in,
  input  wire [ADDR_W-1:0] rd_addr_in,
  output wire [DATA_W-1:0] rd_data_out
);

  reg [DATA_W-1:0] table_mem [0:DEPTH-1];
  reg [DATA_W-1:0] rd_stage_r;
  integer          i;

  // Identity mapping until software loads a curve
  initial
  begin
    for (i = 0; i < DEPTH; i = i + 1)
      table_mem[i] = i[DATA_W-1:0];
  end

  always @(posedge core_clk_in)
  begin
    if (wr_en_in)
      table_mem[wr_addr_in] <= wr_data_in;
    if (rd_en_in)
      rd_stage_r <= table_mem[rd_addr_in];
  end

  //////////////////////////////////////////////////////////////////////////////
  generate
    if (OUT_REG != 0)
    begin : g_out_reg
      reg [DATA_W-1:0] rd_out_r;
      // Extra register matches the output register of embedded block memory
      always @(posedge core_clk_in)
      begin
        if (rd_en_in)
          rd_out_r <= rd_stage_r;
      end
      assign rd_data_out = rd_out_r;
    end
    else
    begin : g_no_out_reg
      assign rd_data_out = rd_stage_r;
    end
  endgenerate

endmodule

//--- verilog/pgl_fifo.v
`timescale 1ns/1ns
module pgl_fifo
#(
  parameter WIDTH = 9,
  parameter DEPTH = 32,
  parameter AW    = 5
)
(
  input  wire             core_clk_in,
  input  wire             clear_in,
  input  wire             enable_in,
  input  wire             in_valid_in,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             in_ready_out,
  output wire             out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input  wire             out_ready_in,
  output wire [AW:0]      count_out
);

  reg [WIDTH-1:0] store_mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      mem_cnt_r;
  reg             out_valid_r;
  reg [WIDTH-1:0] out_data_r;

  wire            push      = in_valid_in & (mem_cnt_r < DEPTH);
  wire            load_out  = ~out_valid_r | out_ready_in;
  wire            mem_empty = (mem_cnt_r == {(AW+1){1'b0}});
  wire            pop_mem   = load_out & ~mem_empty;
  // A word that meets an empty store and a free output goes straight through
  wire            pass_thru = load_out & mem_empty & push;
  wire            store     = push & ~pass_thru;

  assign in_ready_out  = (mem_cnt_r < DEPTH);
  assign out_valid_out = out_valid_r;
  assign out_data_out  = out_data_r;
  assign count_out     = mem_cnt_r + {{AW{1'b0}}, out_valid_r};

  always @(posedge core_clk_in)
  begin
    if (enable_in & store)
      store_mem[wr_ptr_r] <= in_data_in;
  end

  always @(posedge core_clk_in)
  begin
    if (clear_in)
    begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      mem_cnt_r   <= {(AW+1){1'b0}};
      out_valid_r <= 1'b0;
      out_data_r  <= {WIDTH{1'b0}};
    end
    else if (enable_in)
    begin
      if (store)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop_mem)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      mem_cnt_r <= mem_cnt_r + {{AW{1'b0}}, store} - {{AW{1'b0}}, pop_mem};
      if (load_out)
      begin
        if (pop_mem)
        begin
          out_valid_r <= 1'b1;
          out_data_r  <= store_mem[rd_ptr_r];
        end
        else if (pass_thru)
        begin
          out_valid_r <= 1'b1;
          out_data_r  <= in_data_in;
        end
        else
          out_valid_r <= 1'b0;
      end
    end
  end

endmodule

//--- verilog/pgl_top.v
`timescale 1ns/1ns
`include "pgl_consts.vh"
module pgl_top
#(
  parameter       BYPASS_OPT    = 1,
  parameter       REG_INPUT_OPT = 1,
  parameter [1:0] MEM_STYLE     = `PGL_MEM_AUTO,
  parameter       CE_OPT        = 0,
  parameter       SR_OPT        = 0
)
(
  input  wire                   core_clk_in,
  input  wire                   reset_in,
  input  wire                   synchronous_clear_port_in,
  input  wire                   clk_enable_in,
  input  wire                   correction_enable_in,
  input  wire [`PGL_DATA_W-1:0] sample_in,
  input  wire                   sample_valid_in,
  output wire                   sample_ready_out,
  input  wire                   table_wr_en_in,
  input  wire [`PGL_ADDR_W-1:0] table_addr_in,
  input  wire [`PGL_DATA_W-1:0] table_data_in,
  output wire [`PGL_DATA_W-1:0] sample_out,
  output wire                   sample_valid_out,
  output wire                   corrected_out,
  input  wire                   sample_ready_in
);

  //////////////////////////////////////////////////////////////////////////////
  // Memory style decision, shared by the table and the pipeline alignment

  function use_block_mem;
    input [1:0] style;
    input integer width;
    begin
      case (style)
        `PGL_MEM_BLOCK : use_block_mem = (width > `PGL_BLOCK_ABOVE_W);
        `PGL_MEM_DIST  : use_block_mem = !(width < `PGL_DIST_BELOW_W);
        `PGL_MEM_AUTO  : use_block_mem = !(width < `PGL_AUTO_DIST_W);
        default        : use_block_mem = 1'b0;
      endcase
    end
  endfunction

  localparam USE_BLOCK = use_block_mem(MEM_STYLE, `PGL_DATA_W);
  localparam LATENCY   = `PGL_LAT_BASE + ((REG_INPUT_OPT != 0) ? 1 : 0) + (USE_BLOCK ? 1 : 0);

  //////////////////////////////////////////////////////////////////////////////
  // Global hold and clear

  wire run;
  wire clear;
  wire gc_request;

  assign run        = (CE_OPT != 0) ? clk_enable_in : 1'b1;
  // Table contents are never touched by either reset
  assign clear      = reset_in | ((SR_OPT != 0) & synchronous_clear_port_in);
  // Without the bypass option every sample is corrected
  assign gc_request = (BYPASS_OPT != 0) ? correction_enable_in : 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // Upstream ready, kept early enough that in-flight samples always fit

  wire [`PGL_FIFO_CW-1:0] fifo_count;
  wire                    fifo_in_ready;
  reg                     ready_r;
  reg                     ready_nxt;
  wire                    accept;

  always @*
  begin
    ready_nxt = fifo_in_ready & (fifo_count <= `PGL_READY_LIMIT);
  end

  always @(posedge core_clk_in)
  begin
    if (clear)
      ready_r <= `PGL_FLAG_RST;
    else if (run)
      ready_r <= ready_nxt;
  end

  assign sample_ready_out = ready_r;
  assign accept           = sample_valid_in & ready_r;

  //////////////////////////////////////////////////////////////////////////////
  // Optional input stage

  wire                   s0_valid;
  wire [`PGL_DATA_W-1:0] s0_sample;
  wire                   s0_gc;
  wire                   s0_tbl_we;
  wire [`PGL_ADDR_W-1:0] s0_tbl_addr;
  wire [`PGL_DATA_W-1:0] s0_tbl_data;

  generate
    if (REG_INPUT_OPT != 0)
    begin : g_in_reg
      reg                   valid_r;
      reg [`PGL_DATA_W-1:0] sample_r;
      reg                   gc_r;
      reg                   tbl_we_r;
      reg [`PGL_ADDR_W-1:0] tbl_addr_r;
      reg [`PGL_DATA_W-1:0] tbl_data_r;

      always @(posedge core_clk_in)
      begin
        if (clear)
        begin
          valid_r  <= `PGL_FLAG_RST;
          tbl_we_r <= `PGL_FLAG_RST;
        end
        else if (run)
        begin
          valid_r  <= accept;
          tbl_we_r <= table_wr_en_in;
        end
      end

      always @(posedge core_clk_in)
      begin
        if (run)
        begin
          sample_r   <= sample_in;
          gc_r       <= gc_request;
          tbl_addr_r <= table_addr_in;
          tbl_data_r <= table_data_in;
        end
      end

      assign s0_valid    = valid_r;
      assign s0_sample   = sample_r;
      assign s0_gc       = gc_r;
      assign s0_tbl_we   = tbl_we_r;
      assign s0_tbl_addr = tbl_addr_r;
      assign s0_tbl_data = tbl_data_r;
    end
    else
    begin : g_in_direct
      assign s0_valid    = accept;
      assign s0_sample   = sample_in;
      assign s0_gc       = gc_request;
      assign s0_tbl_we   = table_wr_en_in;
      assign s0_tbl_addr = table_addr_in;
      assign s0_tbl_data = table_data_in;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Stage A: address capture

  reg                   sa_valid_r;
  reg [`PGL_DATA_W-1:0] sa_sample_r;
  reg                   sa_gc_r;

  always @(posedge core_clk_in)
  begin
    if (clear)
      sa_valid_r <= `PGL_FLAG_RST;
    else if (run)
      sa_valid_r <= s0_valid;
  end

  always @(posedge core_clk_in)
  begin
    if (run)
    begin
      sa_sample_r <= s0_sample;
      sa_gc_r     <= s0_gc;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Table lookup; stage B rides alongside the memory read register

  wire [`PGL_DATA_W-1:0] lut_data;
  reg                    sb_valid_r;
  reg [`PGL_DATA_W-1:0]  sb_sample_r;
  reg                    sb_gc_r;

  pgl_lut_mem
  #(
    .DATA_W  (`PGL_DATA_W),
    .ADDR_W  (`PGL_ADDR_W),
    .DEPTH   (`PGL_TABLE_DEPTH),
    .OUT_REG (USE_BLOCK ? 1 : 0)
  )
  u_lut_mem
  (
    .core_clk_in (core_clk_in),
    .wr_en_in    (run & s0_tbl_we),
    .wr_addr_in  (s0_tbl_addr),
    .wr_data_in  (s0_tbl_data),
    .rd_en_in    (run),
    .rd_addr_in  (sa_sample_r),
    .rd_data_out (lut_data)
  );

  always @(posedge core_clk_in)
  begin
    if (clear)
      sb_valid_r <= `PGL_FLAG_RST;
    else if (run)
      sb_valid_r <= sa_valid_r;
  end

  always @(posedge core_clk_in)
  begin
    if (run)
    begin
      sb_sample_r <= sa_sample_r;
      sb_gc_r     <= sa_gc_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stage C exists only when the table carries a block-memory output register

  wire                   sc_valid;
  wire [`PGL_DATA_W-1:0] sc_sample;
  wire                   sc_gc;

  generate
    if (USE_BLOCK)
    begin : g_stage_c
      reg                   valid_r;
      reg [`PGL_DATA_W-1:0] sample_r;
      reg                   gc_r;

      always @(posedge core_clk_in)
      begin
        if (clear)
          valid_r <= `PGL_FLAG_RST;
        else if (run)
          valid_r <= sb_valid_r;
      end

      always @(posedge core_clk_in)
      begin
        if (run)
        begin
          sample_r <= sb_sample_r;
          gc_r     <= sb_gc_r;
        end
      end

      assign sc_valid  = valid_r;
      assign sc_sample = sample_r;
      assign sc_gc     = gc_r;
    end
    else
    begin : g_no_stage_c
      assign sc_valid  = sb_valid_r;
      assign sc_sample = sb_sample_r;
      assign sc_gc     = sb_gc_r;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Result select: corrected value or untouched sample

  reg                   res_valid_r;
  reg [`PGL_DATA_W-1:0] res_data_r;
  reg [`PGL_DATA_W-1:0] res_data_nxt;
  reg                   res_gc_r;

  always @*
  begin
    res_data_nxt = sc_gc ? lut_data : sc_sample;
  end

  always @(posedge core_clk_in)
  begin
    if (clear)
    begin
      res_valid_r <= `PGL_FLAG_RST;
      res_gc_r    <= `PGL_FLAG_RST;
      res_data_r  <= `PGL_DATA_RST;
    end
    else if (run)
    begin
      res_valid_r <= sc_valid;
      res_gc_r    <= sc_gc & (BYPASS_OPT != 0);
      res_data_r  <= res_data_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output buffer; its output register is the last pipeline stage

  wire [`PGL_DATA_W:0] fifo_q;

  pgl_fifo
  #(
    .WIDTH (`PGL_DATA_W + 1),
    .DEPTH (`PGL_FIFO_DEPTH),
    .AW    (`PGL_FIFO_AW)
  )
  u_fifo
  (
    .core_clk_in   (core_clk_in),
    .clear_in      (clear),
    .enable_in     (run),
    .in_valid_in   (res_valid_r),
    .in_data_in    ({res_gc_r, res_data_r}),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (sample_valid_out),
    .out_data_out  (fifo_q),
    .out_ready_in  (sample_ready_in),
    .count_out     (fifo_count)
  );

  assign sample_out    = fifo_q[`PGL_DATA_W-1:0];
  assign corrected_out = fifo_q[`PGL_DATA_W];

endmodule

//--- verification/pgl_top_sva.sv
`timescale 1ns/1ns
`include "pgl_consts.vh"
module pgl_top_sva
#(
  parameter       BYPASS_OPT    = 1,
  parameter       REG_INPUT_OPT = 1,
  parameter [1:0] MEM_STYLE     = `PGL_MEM_AUTO,
  parameter       CE_OPT        = 0,
  parameter       SR_OPT        = 0
)
(
  input wire                   core_clk_in,
  input wire                   reset_in,
  input wire                   synchronous_clear_port_in,
  input wire                   clk_enable_in,
  input wire                   correction_enable_in,
  input wire [`PGL_DATA_W-1:0] sample_in,
  input wire                   sample_valid_in,
  input wire                   sample_ready_out,
  input wire                   table_wr_en_in,
  input wire [`PGL_ADDR_W-1:0] table_addr_in,
  input wire [`PGL_DATA_W-1:0] table_data_in,
  input wire [`PGL_DATA_W-1:0] sample_out,
  input wire                   sample_valid_out,
  input wire                   corrected_out,
  input wire                   sample_ready_in
);
  // Distributed table has no output register, so one cycle less
  localparam int LAT = 4 + REG_INPUT_OPT + ((MEM_STYLE == `PGL_MEM_DIST) ? 0 : 1);
  reg  [3:0] ce_run_r;
  // Ports of absent options are ignored by the design, so the checks ignore them too
  wire       ce_on = clk_enable_in || (CE_OPT == 0);
  wire       sr_on = synchronous_clear_port_in && (SR_OPT != 0);
  wire       take  = sample_valid_in & sample_ready_out & ce_on;
  // Counts unbroken running cycles, so a paused pipe never claims exact latency
  always @(posedge core_clk_in)
  begin
    if (reset_in || sr_on || !ce_on)
      ce_run_r <= 4'h0;
    else if (ce_run_r != 4'hF)
      ce_run_r <= ce_run_r + 4'h1;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  //////////////////////////////////////////////////////////////////////////////
  sequence s_fresh;
    $rose(sample_valid_out) && (ce_run_r >= LAT);
  endsequence
  sequence s_stalled;
    sample_valid_out && !sample_ready_in && !sr_on;
  endsequence
  property p_latency;
    s_fresh |-> $past(take, LAT);
  endproperty
  property p_bypass;
    s_fresh ##0 (BYPASS_OPT != 0) && !$past(correction_enable_in, LAT)
      |-> !corrected_out && (sample_out == $past(sample_in, LAT));
  endproperty
  // Without the bypass option every word is corrected but never flagged
  property p_flag;
    s_fresh ##0 ((BYPASS_OPT == 0) || $past(correction_enable_in, LAT)) |-> corrected_out == (BYPASS_OPT != 0);
  endproperty
  property p_stand;
    s_stalled |=> sample_valid_out && $stable(sample_out) && $stable(corrected_out);
  endproperty
  property p_hold;
    !ce_on && !sr_on |=> $stable(sample_out) && $stable(sample_valid_out)
      && $stable(corrected_out) && $stable(sample_ready_out);
  endproperty
  property p_clear;
    sr_on |=> !sample_valid_out && !corrected_out && !sample_ready_out;
  endproperty
  property p_reset;
    disable iff (1'b0) reset_in |=> !sample_valid_out && !corrected_out && (sample_out == 8'h00);
  endproperty
  property p_wake;
    $fell(reset_in) && ce_on && !sr_on |=> sample_ready_out;
  endproperty
  a_latency: assert property (p_latency) else $error("output word not taken at fixed latency");
  a_bypass: assert property (p_bypass) else $error("bypassed word altered or flagged");
  a_flag: assert property (p_flag) else $error("corrected word flag wrong");
  a_stand: assert property (p_stand) else $error("stalled output word changed");
  a_hold: assert property (p_hold) else $error("outputs moved with clock enable low");
  a_clear: assert property (p_clear) else $error("optional reset left flags set");
  a_reset: assert property (p_reset) else $error("reset left output word");
  a_wake: assert property (p_wake) else $error("ready missing after reset release");
endmodule

bind pgl_top pgl_top_sva #(.BYPASS_OPT(BYPASS_OPT), .REG_INPUT_OPT(REG_INPUT_OPT), .MEM_STYLE(MEM_STYLE),
  .CE_OPT(CE_OPT), .SR_OPT(SR_OPT)) u_pgl_top_sva (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .synchronous_clear_port_in(synchronous_clear_port_in),
  .clk_enable_in(clk_enable_in), .correction_enable_in(correction_enable_in), .sample_in(sample_in),
  .sample_valid_in(sample_valid_in), .sample_ready_out(sample_ready_out), .table_wr_en_in(table_wr_en_in),
  .table_addr_in(table_addr_in), .table_data_in(table_data_in), .sample_out(sample_out),
  .sample_valid_out(sample_valid_out), .corrected_out(corrected_out), .sample_ready_in(sample_ready_in));

//--- verification/pgl_sink_model.sv
`timescale 1ns/1ns
module pgl_sink_model
(
  input  wire       core_clk_in,
  input  wire       reset_in,
  input  wire       clk_enable_in,
  input  wire [1:0] mode_in,
  input  wire       sample_valid_in,
  input  wire [7:0] sample_in,
  input  wire       corrected_in,
  output reg        sample_ready_out
);
  reg [8:0] got [$];
  reg [1:0] tick_r = 2'h0;
  // Mode 0 always ready, 1 ready one cycle in four, 2 never ready
  always @(posedge core_clk_in)
  begin
    tick_r <= tick_r + 2'h1;
    sample_ready_out <= !reset_in && ((mode_in == 2'h0) || ((mode_in == 2'h1) && (tick_r == 2'h3)));
    if (!reset_in && clk_enable_in && sample_valid_in && sample_ready_out)
      got.push_back({corrected_in, sample_in});
  end
endmodule

//--- verification/tb.sv
`timescale 1ns/1ns
module tb;
  // Registered input plus block table output register at width 8
  localparam int LAT = 6;
  reg       core_clk_in = 1'b0, reset_in = 1'b1, synchronous_clear_port_in = 1'b0, clk_enable_in = 1'b1;
  reg       correction_enable_in = 1'b0, sample_valid_in = 1'b0, table_wr_en_in = 1'b0;
  reg [7:0] sample_in = 8'h00, table_addr_in = 8'h00, table_data_in = 8'h00;
  reg [1:0] sink_mode = 2'h0;
  wire      sample_ready_out, sample_valid_out, corrected_out, sample_ready_in;
  wire [7:0] sample_out;
  reg [7:0] tbl_m [0:255];
  reg [8:0] exp_q [$];
  reg [8:0] w;
  reg       ok;
  int       n_errors = 0, n_checks = 0, i, k;
  pgl_top #(.CE_OPT(1), .SR_OPT(1)) u_pgl_top (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .synchronous_clear_port_in(synchronous_clear_port_in), .clk_enable_in(clk_enable_in),
    .correction_enable_in(correction_enable_in), .sample_in(sample_in), .sample_valid_in(sample_valid_in),
    .sample_ready_out(sample_ready_out), .table_wr_en_in(table_wr_en_in), .table_addr_in(table_addr_in),
    .table_data_in(table_data_in), .sample_out(sample_out), .sample_valid_out(sample_valid_out),
    .corrected_out(corrected_out), .sample_ready_in(sample_ready_in));
  pgl_sink_model u_pgl_sink_model (.core_clk_in(core_clk_in), .reset_in(reset_in), .clk_enable_in(clk_enable_in),
    .mode_in(sink_mode), .sample_valid_in(sample_valid_out), .sample_in(sample_out),
    .corrected_in(corrected_out), .sample_ready_out(sample_ready_in));
  initial forever #25 core_clk_in = ~core_clk_in;
  //////////////////////////////////////////////////////////////////////////////
  task summarize;
  begin
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task check(input string name, input [8:0] e, input [8:0] g);
  begin
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  end
  endtask
  task timeout;
  begin
    check("wait", 9'h000, 9'h1FF);
    summarize;
  end
  endtask
  task tbl_write(input [7:0] a, input [7:0] d);
  begin
    table_wr_en_in <= 1'b1;
    table_addr_in <= a;
    table_data_in <= d;
    tbl_m[a] = d;
    @(posedge core_clk_in);
    table_wr_en_in <= 1'b0;
    @(posedge core_clk_in);
  end
  endtask
  // Holds the word until taken; a short bound lets the fill test stop at refusal
  task send(input [7:0] x, input g, input int bound, output reg ok);
    int n;
  begin
    sample_in <= x; // Full-width samples need no alignment
    correction_enable_in <= g;
    sample_valid_in <= 1'b1;
    ok = 1'b0;
    for (n = 0; n < bound && !ok; n++)
    begin
      @(negedge core_clk_in);
      ok = (sample_ready_out === 1'b1) && clk_enable_in;
      @(posedge core_clk_in);
    end
    if (ok)
      exp_q.push_back({g, g ? tbl_m[x] : x});
    else if (bound > 50)
      timeout;
  end
  endtask
  task drain;
    int n;
  begin
    for (n = 0; n < 2000 && u_pgl_sink_model.got.size() < exp_q.size(); n++)
      @(posedge core_clk_in);
    if (n == 2000)
      timeout;
    while (exp_q.size() > 0)
      check("sample_out", exp_q.pop_front(), u_pgl_sink_model.got.pop_front());
    check("extra_words", 9'h000, 9'(u_pgl_sink_model.got.size()));
  end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (i = 0; i < 256; i++)
      tbl_m[i] = i[7:0]; // Address order, final outputs
    repeat (12) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    tbl_write(8'h00, 8'h7E);
    tbl_write(8'h55, 8'hA5);
    tbl_write(8'hFF, 8'h01);
    for (i = 0; i < 8; i++)
      send(8'h55 * i[1:0], i < 4, 200, ok);
    sample_valid_in <= 1'b0;
    drain;
    @(posedge core_clk_in);
    send(8'h55, 1'b1, 200, ok);
    sample_valid_in <= 1'b0;
    for (k = 1; k < 20; k++)
    begin
      @(negedge core_clk_in);
      if (sample_valid_out === 1'b1)
        break;
    end
    check("latency", 9'(LAT), 9'(k));
    @(posedge core_clk_in);
    drain;
    // Fill the output buffer against a stalled sink until it refuses
    sink_mode <= 2'h2;
    ok = 1'b1;
    for (i = 0; i < 40 && ok; i++)
      send(i[7:0], i[0], 20, ok);
    sample_valid_in <= 1'b0;
    check("fill_count_in_range", 9'h001, {8'h00, exp_q.size() >= 24 && exp_q.size() <= 32});
    @(negedge core_clk_in);
    check("sample_ready_out", 9'h000, {8'h00, sample_ready_out});
    @(posedge core_clk_in);
    sink_mode <= 2'h1;
    repeat (9) @(posedge core_clk_in);
    clk_enable_in <= 1'b0;
    @(negedge core_clk_in);
    w = {corrected_out, sample_out};
    k = u_pgl_sink_model.got.size();
    repeat (10) @(posedge core_clk_in);
    @(negedge core_clk_in);
    check("held_word", w, {corrected_out, sample_out});
    check("held_count", 9'(k), 9'(u_pgl_sink_model.got.size()));
    @(posedge core_clk_in);
    clk_enable_in <= 1'b1;
    drain;
    // Clear with words buffered and none left in flight; the table must survive it
    sink_mode <= 2'h2;
    for (i = 0; i < 5; i++)
      send(8'hA0 + i[7:0], 1'b1, 200, ok);
    sample_valid_in <= 1'b0;
    repeat (10) @(posedge core_clk_in);
    synchronous_clear_port_in <= 1'b1;
    @(posedge core_clk_in);
    synchronous_clear_port_in <= 1'b0;
    exp_q.delete();
    repeat (3) @(negedge core_clk_in);
    check("sample_valid_out", 9'h000, {8'h00, sample_valid_out});
    @(posedge core_clk_in);
    sink_mode <= 2'h0;
    send(8'hFF, 1'b1, 200, ok);
    sample_valid_in <= 1'b0;
    drain;
    summarize;
  end
endmodule
